// ---- cmc_defines.svh ----
// cmc_defines.svh: offsets, fields, reset values and timing counts for cursor_move_control
// assumes a 10 MHz core clock and a 7-bit display character counter
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH

// ==========================================================
// register byte offsets
`define CMC_ADDR_CMD 8'h00
`define CMC_ADDR_CTRL 8'h04
`define CMC_ADDR_STATUS 8'h08

// ==========================================================
// command register bits, write one to issue
`define CMC_CMD_DOWN 0
`define CMC_CMD_UP 1
`define CMC_CMD_LEFT 2
`define CMC_CMD_RIGHT 3
`define CMC_CMD_CR 4
`define CMC_CMD_HOME 5

// ==========================================================
// control register bits and reset value
`define CMC_CTRL_KEY_EN 0
`define CMC_CTRL_REP_EN 1
`define CMC_CTRL_RESET 2'h3

// ==========================================================
// status register fields
`define CMC_ST_CHAR_LSB 0
`define CMC_ST_LINE_LSB 8
`define CMC_ST_BUSY 16
`define CMC_ST_KEY_LSB 20

// ==========================================================
// character counter decodes and cursor limits
`define CMC_CNT_SET 7'h4c
`define CMC_CNT_CLR 7'h52
`define CMC_CHAR_LAST 7'h47
`define CMC_LINE_LAST 5'h18

// ==========================================================
// timing: clock rate in MHz, times in microseconds
`define CMC_CLK_MHZ 32'h0000_000a
`define CMC_DEBOUNCE_US 32'h0000_2710
`define CMC_REPEAT_DLY_US 32'h0007_a120
`define CMC_DEBOUNCE_CYC (`CMC_DEBOUNCE_US * `CMC_CLK_MHZ)
`define CMC_REPEAT_DLY_CYC (`CMC_REPEAT_DLY_US * `CMC_CLK_MHZ)

`endif

// ---- cmc_pkg.sv ----
// cmc_pkg.sv: types shared by cursor_move_control and its bench
// assumes an AHB-Lite master with 32-bit data
package cmc_pkg;

  // ==========================================================
  // AHB-Lite request and response carriers
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } cmc_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } cmc_ahb_rsp_t;

  // ==========================================================
  // one bit per cursor direction
  typedef struct packed {
    logic right;
    logic left;
    logic up;
    logic down;
  } cmc_dir_t;

  // ==========================================================
  // move sequencer states
  typedef enum logic [2:0] {
    CMC_IDLE,
    CMC_WAIT_SET,
    CMC_PULSE,
    CMC_WAIT_REL,
    CMC_ACK
  } cmc_state_t;

endpackage : cmc_pkg

// ---- cmc_move_control.sv ----
// cmc_move_control.sv: cursor position counters and their move sequencer, AHB-Lite slave
// assumes char_count_in is the display character counter, synchronous to clk_in
//
// Behaviour
// - right: drive char steer-down low first
// - latch set at 76, cleared at 82
// - char step only while advance permit high
// - zero decode gates character counter clock
// - after 82 and release, pulse accepted
// - left: steer-up low, count down one
// - vertical moves use same 76/82 pulse
// - up: line steer-up low, decrement one
// - no line step up from zero
// - down: line steer-down low, increment one
// - arrow keys debounced before making a move
// - held key repeats on 7.5 Hz tick
// - debounced closure reported back to keyboard
// - carriage return clears character counter only
// - home from power-on, host or key
// - home clears both counters
// - character counter spans 72 positions
// - line counter spans 25 lines
`timescale 1ns/1ns
`default_nettype none
`include "cmc_defines.svh"

module cmc_move_control #(
  parameter int DEBOUNCE_CYC = `CMC_DEBOUNCE_CYC,
  parameter int REPEAT_CYC = `CMC_REPEAT_DLY_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register bus
  input wire cmc_pkg::cmc_ahb_req_t ahb_in,
  output cmc_pkg::cmc_ahb_rsp_t ahb_out,
  // display timing
  input wire logic [6:0] char_count_in,
  input wire logic cursor_advance_in,
  input wire logic repeat_tick_in,
  // host commands and keys, active low
  input wire cmc_pkg::cmc_dir_t host_cmd_n_in,
  input wire cmc_pkg::cmc_dir_t arrow_key_n_in,
  input wire logic cr_n_in,
  input wire logic home_cmd_n_in,
  input wire logic home_key_n_in,
  input wire logic por_n_in,
  // cursor position and steering
  output logic [6:0] char_pos_out,
  output logic [4:0] line_pos_out,
  output logic char_steer_up_n_out,
  output logic char_steer_down_n_out,
  output logic line_steer_up_n_out,
  output logic line_steer_down_n_out,
  output logic move_pulse_out,
  // handshake and key report
  output logic accepted_out,
  output cmc_pkg::cmc_dir_t key_closed_out
);

  localparam int CW = $clog2(REPEAT_CYC + 1);

  // ==========================================================
  // bus slave state
  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;
  logic [31:0] rdata;
  logic [1:0] ctrl;
  logic addr_ok;
  logic cmd_wr;
  logic [3:0] bus_dir;
  logic bus_cr;
  logic bus_home;

  // ==========================================================
  // sequencer and key state
  cmc_pkg::cmc_state_t state;
  logic [3:0] pend;
  logic [3:0] sel;
  logic [3:0] host_d;
  logic [3:0] host_fall;
  logic [3:0] key_evt;
  logic [3:0] take;
  logic [3:0] pick;
  logic [3:0] clean;
  logic rep_d;
  logic rep_edge;
  logic at_set;
  logic at_clr;
  logic home;
  logic cr;
  logic char_ok;
  logic line_ok;
  logic released;

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign addr_ok = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end
    else
    begin
      dp_valid <= addr_ok;
      dp_write <= ahb_in.hwrite;
      dp_addr <= ahb_in.haddr[7:0];
    end
  end

  // read data is captured in the address phase so hrdata leaves a flop
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata <= 32'h0000_0000;
    else if (addr_ok && !ahb_in.hwrite)
    begin
      rdata <= 32'h0000_0000;
      case (ahb_in.haddr[7:0])
        `CMC_ADDR_CTRL: rdata[1:0] <= ctrl;
        `CMC_ADDR_STATUS:
        begin
          rdata[`CMC_ST_CHAR_LSB +: 7] <= char_pos_out;
          rdata[`CMC_ST_LINE_LSB +: 5] <= line_pos_out;
          rdata[`CMC_ST_BUSY] <= (state != cmc_pkg::CMC_IDLE) || (pend != 4'h0);
          rdata[`CMC_ST_KEY_LSB +: 4] <= clean;
        end
        default: rdata <= 32'h0000_0000;
      endcase
    end
  end

  assign ahb_out.hrdata = rdata;
  assign ahb_out.hreadyout = 1'b1;
  assign ahb_out.hresp = 1'b0;

  assign cmd_wr = dp_valid && dp_write && (dp_addr == `CMC_ADDR_CMD);
  assign bus_dir = cmd_wr ? ahb_in.hwdata[3:0] : 4'h0;
  assign bus_cr = cmd_wr && ahb_in.hwdata[`CMC_CMD_CR];
  assign bus_home = cmd_wr && ahb_in.hwdata[`CMC_CMD_HOME];

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ctrl <= `CMC_CTRL_RESET;
    else if (dp_valid && dp_write && (dp_addr == `CMC_ADDR_CTRL))
      ctrl <= ahb_in.hwdata[1:0];
  end

  // ==========================================================
  // host command edges: requests idle high and pulse low
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      host_d <= 4'hf;
      rep_d <= 1'b0;
    end
    else
    begin
      host_d <= host_cmd_n_in;
      rep_d <= repeat_tick_in;
    end
  end

  assign host_fall = host_d & ~host_cmd_n_in;
  assign rep_edge = repeat_tick_in && !rep_d;

  // ==========================================================
  // arrow keys: one counter per key does both filter and repeat delay
  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_key
      logic [CW-1:0] cnt;
      logic evt;
      always_ff @(posedge clk_in)
      begin
        if (rst_in || arrow_key_n_in[i] || !ctrl[`CMC_CTRL_KEY_EN])
        begin
          // any bounce back high restarts the filter
          cnt <= '0;
          clean[i] <= 1'b0;
          evt <= 1'b0;
        end
        else
        begin
          evt <= 1'b0;
          if (cnt != CW'(REPEAT_CYC))
            cnt <= cnt + CW'(1);
          if (cnt == CW'(DEBOUNCE_CYC - 1))
          begin
            clean[i] <= 1'b1;
            evt <= 1'b1;
          end
          if ((cnt == CW'(REPEAT_CYC)) && ctrl[`CMC_CTRL_REP_EN] && rep_edge)
            evt <= 1'b1;
        end
      end
      assign key_evt[i] = evt;
    end
  endgenerate

  assign key_closed_out = clean;

  // ==========================================================
  // pending requests: a new request wins over its own take
  always_comb
  begin
    pick = 4'h0;
    if (pend[3])
      pick = 4'h8;
    else if (pend[2])
      pick = 4'h4;
    else if (pend[1])
      pick = 4'h2;
    else if (pend[0])
      pick = 4'h1;
  end

  assign take = (state == cmc_pkg::CMC_IDLE) ? pick : 4'h0;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      pend <= 4'h0;
    else
      pend <= (pend & ~take) | host_fall | key_evt | bus_dir;
  end

  // ==========================================================
  // move sequencer
  assign at_set = (char_count_in == `CMC_CNT_SET);
  assign at_clr = (char_count_in == `CMC_CNT_CLR);
  assign released = ((sel & ~host_cmd_n_in) == 4'h0);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= cmc_pkg::CMC_IDLE;
      sel <= 4'h0;
      move_pulse_out <= 1'b0;
      accepted_out <= 1'b0;
    end
    else
    begin
      case (state)
        cmc_pkg::CMC_IDLE:
        begin
          accepted_out <= 1'b0;
          if (pick != 4'h0)
          begin
            sel <= pick;
            state <= cmc_pkg::CMC_WAIT_SET;
          end
        end
        cmc_pkg::CMC_WAIT_SET:
          if (at_set)
          begin
            move_pulse_out <= 1'b1;
            state <= cmc_pkg::CMC_PULSE;
          end
        cmc_pkg::CMC_PULSE:
          if (at_clr)
          begin
            move_pulse_out <= 1'b0;
            state <= cmc_pkg::CMC_WAIT_REL;
          end
        cmc_pkg::CMC_WAIT_REL:
          if (released)
          begin
            accepted_out <= 1'b1;
            state <= cmc_pkg::CMC_ACK;
          end
        cmc_pkg::CMC_ACK:
        begin
          accepted_out <= 1'b0;
          sel <= 4'h0;
          state <= cmc_pkg::CMC_IDLE;
        end
        default:
        begin
          sel <= 4'h0;
          move_pulse_out <= 1'b0;
          accepted_out <= 1'b0;
          state <= cmc_pkg::CMC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // steering: set as soon as a move is selected, before its clock
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      char_steer_up_n_out <= 1'b1;
      char_steer_down_n_out <= 1'b1;
      line_steer_up_n_out <= 1'b1;
      line_steer_down_n_out <= 1'b1;
    end
    else if (state == cmc_pkg::CMC_IDLE)
    begin
      char_steer_down_n_out <= !pick[3];
      char_steer_up_n_out <= !pick[2];
      line_steer_up_n_out <= !pick[1];
      line_steer_down_n_out <= !pick[0];
    end
  end

  // ==========================================================
  // counter clock gating, evaluated on the step edge at count 76
  always_comb
  begin
    char_ok = 1'b0;
    line_ok = 1'b0;
    if (sel[3])
      char_ok = cursor_advance_in && (char_pos_out != `CMC_CHAR_LAST);
    else if (sel[2])
      char_ok = cursor_advance_in && (char_pos_out != 7'h00);
    if (sel[1])
      line_ok = (line_pos_out != 5'h00);
    else if (sel[0])
      line_ok = (line_pos_out != `CMC_LINE_LAST);
  end

  // clears are level sensitive and take effect on the next edge
  assign home = !por_n_in || !home_cmd_n_in || !home_key_n_in || bus_home;
  assign cr = !cr_n_in || bus_cr;

  // ==========================================================
  // cursor position counters
  always_ff @(posedge clk_in)
  begin
    if (rst_in || home || cr)
      char_pos_out <= 7'h00;
    else if ((state == cmc_pkg::CMC_WAIT_SET) && at_set && char_ok)
    begin
      if (sel[3])
        char_pos_out <= char_pos_out + 7'h01;
      else
        char_pos_out <= char_pos_out - 7'h01;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || home)
      line_pos_out <= 5'h00;
    else if ((state == cmc_pkg::CMC_WAIT_SET) && at_set && line_ok)
    begin
      if (sel[1])
        line_pos_out <= line_pos_out - 5'h01;
      else
        line_pos_out <= line_pos_out + 5'h01;
    end
  end

endmodule : cmc_move_control
`default_nettype wire

// ---- cmc_pkg_order_note.sv ----
`timescale 1ns/1ns

// ---- cmc_far_model.sv ----
// cmc_far_model.sv: host command decoder and key matrix stand-in
// assumes the bench strobes go_in for one clk_in cycle
`timescale 1ns/1ns
`default_nettype none
module cmc_far_model (
  // clock
  input wire logic clk_in,
  // bench requests
  input wire cmc_pkg::cmc_dir_t go_in,
  input wire logic [3:0] hold_in,
  input wire cmc_pkg::cmc_dir_t key_in,
  input wire logic accepted_in,
  // toward the block
  output cmc_pkg::cmc_dir_t host_cmd_n_out,
  output cmc_pkg::cmc_dir_t arrow_key_n_out,
  output logic done_out
);
  // =====
  // holding register
  logic [3:0] left_cnt;
  initial
  begin
    host_cmd_n_out = 4'hf;
    left_cnt = 4'h0;
    done_out = 1'b0;
  end
  // pin held low a few cycles only, released well before count 82
  always @(posedge clk_in)
  begin
    if (go_in != 4'h0)
    begin
      host_cmd_n_out <= ~go_in;
      left_cnt <= hold_in;
      done_out <= 1'b0;
    end
    else if (left_cnt != 4'h0)
      left_cnt <= left_cnt - 4'h1;
    else
      host_cmd_n_out <= 4'hf;
    if (accepted_in)
      done_out <= 1'b1;
  end
  assign arrow_key_n_out = ~key_in;
endmodule : cmc_far_model
`default_nettype wire

// ---- cmc_move_control_assertions.sv ----
// cmc_move_control_assertions.sv: checker bound to cmc_move_control
// assumes char_count_in advances on clk_in
`timescale 1ns/1ns
`default_nettype none
module cmc_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // watched pins
  input wire logic [6:0] char_count_in,
  input wire logic cursor_advance_in,
  input wire logic cr_n_in,
  input wire logic home_cmd_n_in,
  input wire logic home_key_n_in,
  input wire logic por_n_in,
  input wire logic [6:0] char_pos_out,
  input wire logic [4:0] line_pos_out,
  input wire logic char_steer_up_n_out,
  input wire logic char_steer_down_n_out,
  input wire logic line_steer_up_n_out,
  input wire logic line_steer_down_n_out,
  input wire logic move_pulse_out,
  input wire logic accepted_out
);
  // =====
  // helpers
  logic home;
  logic calm;
  logic [3:0] steer_n;
  assign home = !(home_cmd_n_in && home_key_n_in && por_n_in);
  assign steer_n = {char_steer_up_n_out, char_steer_down_n_out, line_steer_up_n_out,
    line_steer_down_n_out};
  assign calm = !home && cr_n_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // a step edge with no clear pending, since clears win
  sequence s_step;
    $rose(move_pulse_out) && $past(calm);
  endsequence
  // =====
  // properties
  property p_set;
    $rose(move_pulse_out) |-> $past(char_count_in) == 7'h4c;
  endproperty
  a_set: assert property (p_set) else $error("pulse rose off 76");
  property p_clr;
    $fell(move_pulse_out) |-> $past(char_count_in) == 7'h52;
  endproperty
  a_clr: assert property (p_clr) else $error("pulse fell off 82");
  property p_right;
    s_step ##0 (!char_steer_down_n_out && $past(cursor_advance_in)
      && $past(char_pos_out) < 7'h47) |-> char_pos_out == $past(char_pos_out) + 7'h01;
  endproperty
  a_right: assert property (p_right) else $error("right step wrong");
  property p_left;
    s_step ##0 (!char_steer_up_n_out && $past(cursor_advance_in)
      && $past(char_pos_out) != 7'h00) |-> char_pos_out == $past(char_pos_out) - 7'h01;
  endproperty
  a_left: assert property (p_left) else $error("left step wrong");
  property p_up;
    s_step ##0 (!line_steer_up_n_out && $past(line_pos_out) != 5'h00)
      |-> line_pos_out == $past(line_pos_out) - 5'h01;
  endproperty
  a_up: assert property (p_up) else $error("up step wrong");
  property p_down;
    s_step ##0 (!line_steer_down_n_out && $past(line_pos_out) < 5'h18)
      |-> line_pos_out == $past(line_pos_out) + 5'h01;
  endproperty
  a_down: assert property (p_down) else $error("down step wrong");
  property p_edge;
    s_step ##0 ((!line_steer_up_n_out && $past(line_pos_out) == 5'h00)
      || (!line_steer_down_n_out && $past(line_pos_out) == 5'h18)) |-> $stable(line_pos_out);
  endproperty
  a_edge: assert property (p_edge) else $error("line left its range");
  property p_cr;
    !$past(cr_n_in) |-> char_pos_out == 7'h00;
  endproperty
  a_cr: assert property (p_cr) else $error("return did not clear");
  property p_home;
    $past(home) |-> char_pos_out == 7'h00 && line_pos_out == 5'h00;
  endproperty
  a_home: assert property (p_home) else $error("home did not clear");
  // steering must already stand, one line only, when the pulse starts
  property p_steer;
    $rose(move_pulse_out) |-> $stable(steer_n) && $countones(steer_n) == 3;
  endproperty
  a_steer: assert property (p_steer) else $error("steer not set before pulse");
  property p_ack;
    $rose(accepted_out) |-> !move_pulse_out ##1 !accepted_out;
  endproperty
  a_ack: assert property (p_ack) else $error("accept pulse wrong");
  c_step: cover property ($rose(move_pulse_out));
  c_ack: cover property ($rose(accepted_out));
  c_home: cover property ($past(home));
endmodule : cmc_checker
bind cmc_move_control cmc_checker u_chk (
  .clk_in, .rst_in, .char_count_in, .cursor_advance_in, .cr_n_in, .home_cmd_n_in,
  .home_key_n_in, .por_n_in, .char_pos_out, .line_pos_out, .char_steer_up_n_out,
  .char_steer_down_n_out, .line_steer_up_n_out, .line_steer_down_n_out,
  .move_pulse_out, .accepted_out
);
`default_nettype wire

// ---- cursor_move_control_tb.sv ----
// cursor_move_control_tb.sv: self-checking bench for cmc_move_control
// assumes short debounce and repeat counts to keep the run brief
`timescale 1ns/1ns
`default_nettype none
module cursor_move_control_tb;
  // =====
  // stimulus and observation
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [6:0] cnt = 7'h00;
  logic adv = 1'b1;
  logic tick = 1'b0;
  logic [3:0] clr_n = 4'hf;
  cmc_pkg::cmc_ahb_req_t req = '0;
  cmc_pkg::cmc_ahb_rsp_t rsp;
  cmc_pkg::cmc_dir_t go = '0;
  cmc_pkg::cmc_dir_t key = '0;
  cmc_pkg::cmc_dir_t hcmd_n;
  cmc_pkg::cmc_dir_t akey_n;
  cmc_pkg::cmc_dir_t kc;
  logic [6:0] cpos;
  logic [4:0] lpos;
  logic [3:0] steer;
  logic mp;
  logic acc;
  logic done;
  logic [31:0] rd;
  int n_fail = 0;
  int comparisons = 0;
  int i;
  always #50 clk_in = ~clk_in;
  // display counter, 96 counts a line
  always @(posedge clk_in) cnt <= (cnt == 7'h5f) ? 7'h00 : cnt + 7'h01;
  cmc_move_control #(.DEBOUNCE_CYC(4), .REPEAT_CYC(20)) u_dut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ahb_in({req[71:1], rsp.hreadyout}),
    .ahb_out(rsp),
    .char_count_in(cnt),
    .cursor_advance_in(adv),
    .repeat_tick_in(tick),
    .host_cmd_n_in(hcmd_n),
    .arrow_key_n_in(akey_n),
    .cr_n_in(clr_n[3]),
    .home_cmd_n_in(clr_n[0]),
    .home_key_n_in(clr_n[1]),
    .por_n_in(clr_n[2]),
    .char_pos_out(cpos),
    .line_pos_out(lpos),
    .char_steer_up_n_out(steer[3]),
    .char_steer_down_n_out(steer[2]),
    .line_steer_up_n_out(steer[1]),
    .line_steer_down_n_out(steer[0]),
    .move_pulse_out(mp),
    .accepted_out(acc),
    .key_closed_out(kc)
  );
  cmc_far_model u_far (
    .clk_in(clk_in),
    .go_in(go),
    .hold_in(4'h6),
    .key_in(key),
    .accepted_in(acc),
    .host_cmd_n_out(hcmd_n),
    .arrow_key_n_out(akey_n),
    .done_out(done)
  );
  // =====
  // shared tasks
  task print_verdict;
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // bounded wait: 0 accept, 1 far side done, 2 bus ready
  task wait_on(input int sel);
    for (int k = 0; k < 400; k++)
    begin
      @(posedge clk_in);
      #1;
      if (((sel == 0) ? acc : (sel == 1) ? done : rsp.hreadyout) === 1'b1)
        return;
    end
    n_fail++;
    $display("BAD %0t wait ran out", $time);
    print_verdict;
  endtask : wait_on
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    req.hsel <= 1'b1;
    req.haddr <= {24'h00_0000, a};
    req.htrans <= 2'h2;
    req.hwrite <= w;
    req.hsize <= 3'h2;
    wait_on(2);
    req.htrans <= 2'h0;
    req.hwdata <= wd;
    wait_on(2);
    rd = rsp.hrdata;
  endtask : ahb
  // command write, then position {char, line} once accepted
  task mv(input int b, input logic [11:0] e);
    ahb(1'b1, 8'h00, 32'h0000_0001 << b);
    wait_on(0);
    chk({cpos, lpos}, e);
  endtask : mv
  task blip(input int k);
    @(posedge clk_in);
    clr_n[k] <= 1'b0;
    @(posedge clk_in);
    clr_n <= 4'hf;
    @(posedge clk_in);
    #1;
  endtask : blip
  // =====
  // scenarios
  task t_reset;
    chk({cpos, lpos, steer, mp, acc}, 18'h0_003c);
    ahb(1'b0, 8'h04, '0);
    chk(rd, 32'h0000_0003);
    ahb(1'b0, 8'h0c, '0);
    chk(rd, 32'h0000_0000);
  endtask : t_reset
  task t_horiz;
    @(posedge clk_in);
    go <= 4'h8;
    @(posedge clk_in);
    go <= 4'h0;
    wait_on(1);
    chk({cpos, lpos}, 12'h020);
    mv(2, 12'h000);
    mv(2, 12'h000);
    @(posedge clk_in);
    adv <= 1'b0;
    mv(3, 12'h000);
    @(posedge clk_in);
    adv <= 1'b1;
  endtask : t_horiz
  task t_vert;
    mv(0, 12'h001);
    mv(1, 12'h000);
    mv(1, 12'h000);
    for (i = 1; i < 26; i++)
      mv(0, 12'((i < 25) ? i : 24));
  endtask : t_vert
  task t_clear;
    mv(3, 12'h038);
    blip(3);
    chk({cpos, lpos}, 12'h018);
    @(posedge clk_in);
    clr_n[3] <= 1'b0;
    mv(3, 12'h018);
    @(posedge clk_in);
    clr_n[3] <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      mv(3, (i == 0) ? 12'h038 : 12'h020);
      blip(i);
      chk({cpos, lpos}, 12'h000);
    end
  endtask : t_clear
  task t_key;
    @(posedge clk_in);
    key <= 4'h8;
    wait_on(0);
    chk({kc, cpos}, 11'h401);
    @(posedge clk_in);
    tick <= 1'b1;
    wait_on(0);
    chk(cpos, 7'h02);
    @(posedge clk_in);
    tick <= 1'b0;
    key <= 4'h0;
    repeat (3) @(posedge clk_in);
    #1;
    chk(kc, 4'h0);
  endtask : t_key
  // bus clears, status word, key enable and a reset in mid-run
  task t_bus;
    mv(0, 12'h041);
    ahb(1'b0, 8'h08, '0);
    chk(rd, 32'h0000_0102);
    ahb(1'b1, 8'h00, 32'h0000_0010);
    chk({cpos, lpos}, 12'h001);
    ahb(1'b1, 8'h00, 32'h0000_0008);
    ahb(1'b0, 8'h08, '0);
    chk(rd, 32'h0001_0100);
    wait_on(0);
    chk({cpos, lpos}, 12'h021);
    ahb(1'b1, 8'h00, 32'h0000_0020);
    chk({cpos, lpos}, 12'h000);
    ahb(1'b1, 8'h04, '0);
    ahb(1'b0, 8'h04, '0);
    chk(rd, 32'h0000_0000);
    @(posedge clk_in);
    key <= 4'h8;
    repeat (30) @(posedge clk_in);
    #1;
    chk({kc, cpos}, 11'h000);
    @(posedge clk_in);
    key <= 4'h0;
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    ahb(1'b0, 8'h04, '0);
    chk(rd, 32'h0000_0003);
  endtask : t_bus
  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset;
    t_horiz;
    t_vert;
    t_clear;
    t_key;
    t_bus;
    print_verdict;
  end
endmodule : cursor_move_control_tb
`default_nettype wire
